// >>> shared/biu_regs.vh
// constants for the branch instruction unit
// How it works
// - short jump: two bytes, signed offset
// - long jump: three bytes, 16-bit target
// - block jump keeps upper five bits of the next address
// - three bits from opcode, eight from byte
// - indirect jump loads accumulator plus pointer
// - long call carries full 16-bit target
// - block call stays in the 2k of the next address
// - return resumes after the call
// - interrupt return also signals interrupt done
// - no interrupt active: plain return only
// - conditional branches use signed relative offset
// - zero tests look at accumulator directly
// - loop decrements operand, branches if nonzero
// - compare branches only when operands differ
// - compare clears carry when first >= second
`ifndef BIU_REGS_VH
`define BIU_REGS_VH
// opcode bytes of the handled instructions
`define BIU_OP_SHORT_JUMP 8'h80
`define BIU_OP_LONG_JUMP 8'h02
`define BIU_OP_LONG_CALL 8'h12
`define BIU_OP_SUB_RETURN 8'h22
`define BIU_OP_INT_RETURN 8'h32
`define BIU_OP_JMP_IND 8'h73
`define BIU_OP_ACC_ZERO 8'h60
`define BIU_OP_ACC_NONZERO 8'h70
`define BIU_OP_NO_OPERATION 8'h00
// block jump/call: low five opcode bits pattern
`define BIU_ABS_MASK 8'h1f
`define BIU_ABS_JMP 8'h01
`define BIU_ABS_CALL 8'h11
// decrement-branch and compare-branch opcode groups
`define BIU_LOOP_DIR 8'hd5
`define BIU_LOOP_REG_HI 5'h1b
`define BIU_CMP_HI 4'hb
`define BIU_CMP_LO_MIN 4'h4
// lengths in bytes
`define BIU_LEN1 16'h0001
`define BIU_LEN2 16'h0002
`define BIU_LEN3 16'h0003
// field positions
`define BIU_ABS_LO 11
`define BIU_ABS_HI_BIT 5
// reset values
`define BIU_PC_RST 16'h0000
`define BIU_SP_RST 4'h0
`endif

// >>> rtl/biu_stack.v
// return-address stack in flip-flops for the branch unit
`default_nettype none
module biu_stack #(
  parameter DEPTH_W = 4
) (
  input wire ref_clk, // core clock
  input wire srst, // synchronous reset, active high
  input wire ce, // clock enable
  input wire push, // save push_addr
  input wire pop, // remove top entry
  input wire [15:0] push_addr, // address to save
  output wire [15:0] top_addr, // current top entry
  output wire empty // no entry stored
);
  localparam DEPTH = 1 << DEPTH_W;
  reg [15:0] mem [0:DEPTH-1];
  reg [DEPTH_W-1:0] sp;
  reg [DEPTH_W:0] count;
  wire [DEPTH_W-1:0] top_idx;

  assign top_idx = sp - {{(DEPTH_W-1){1'b0}}, 1'b1};
  assign top_addr = mem[top_idx];
  assign empty = (count == {(DEPTH_W+1){1'b0}});

  // pointer moves; overflow wraps and loses the oldest frame
  always @(posedge ref_clk) begin
    if (srst) begin
      sp <= {DEPTH_W{1'b0}};
      count <= {(DEPTH_W+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        mem[sp] <= push_addr;
        sp <= sp + {{(DEPTH_W-1){1'b0}}, 1'b1};
        if (count != DEPTH[DEPTH_W:0])
          count <= count + {{DEPTH_W{1'b0}}, 1'b1};
      end else if (pop && !empty) begin
        sp <= top_idx;
        count <= count - {{DEPTH_W{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/biu_branch_unit.v
// program-flow decoder: jumps, calls, returns and branches
`include "biu_regs.vh"
`default_nettype none
module biu_branch_unit #(
  parameter STACK_W = 4
) (
  input wire ref_clk, // core clock, 20 mhz
  input wire srst, // synchronous reset, active high
  input wire ce, // clock enable, freezes all state when low
  input wire exec, // one-cycle strobe: execute instruction
  input wire [7:0] op, // opcode byte
  input wire [7:0] byte1, // second instruction byte
  input wire [7:0] byte2, // third instruction byte
  input wire [15:0] pc_in, // address of the opcode
  input wire [7:0] acc, // accumulator
  input wire [15:0] data_pointer, // data pointer register
  input wire [7:0] opnd_a, // first operand / loop counter byte
  input wire [7:0] opnd_b, // second operand byte of compare
  input wire carry_in, // current carry flag
  input wire int_active, // an interrupt is in progress
  output reg [15:0] pc_out, // next program counter
  output reg pc_valid, // pulse: pc_out valid
  output reg taken, // pulse: flow changed
  output reg carry_out, // carry after compare
  output reg carry_we, // pulse: write carry_out
  output reg [7:0] dec_out, // decremented loop byte
  output reg dec_we, // pulse: write dec_out back
  output reg int_done, // pulse: interrupt finished
  output reg stack_empty // return stack holds nothing
);

  ////////////////////////////////////////////////////////////////
  // decode
  wire is_short = (op == `BIU_OP_SHORT_JUMP);
  wire is_long = (op == `BIU_OP_LONG_JUMP);
  wire is_long_call = (op == `BIU_OP_LONG_CALL);
  wire is_sub_return = (op == `BIU_OP_SUB_RETURN);
  wire is_int_return = (op == `BIU_OP_INT_RETURN);
  wire is_ind = (op == `BIU_OP_JMP_IND);
  wire is_acc_zero_br = (op == `BIU_OP_ACC_ZERO);
  wire is_acc_nz_br = (op == `BIU_OP_ACC_NONZERO);
  wire is_block_jump = ((op & `BIU_ABS_MASK) == `BIU_ABS_JMP);
  wire is_block_call = ((op & `BIU_ABS_MASK) == `BIU_ABS_CALL);
  wire is_loop_dir = (op == `BIU_LOOP_DIR);
  wire is_loop_reg = (op[7:3] == `BIU_LOOP_REG_HI);
  wire is_loop = is_loop_dir | is_loop_reg;
  wire is_compare = (op[7:4] == `BIU_CMP_HI) &&
                    (op[3:0] >= `BIU_CMP_LO_MIN);

  ////////////////////////////////////////////////////////////////
  // instruction length and next address
  reg [15:0] len;
  always @* begin
    if (is_long || is_long_call || is_compare || is_loop_dir)
      len = `BIU_LEN3;
    else if (is_short || is_block_jump || is_block_call ||
             is_acc_zero_br || is_acc_nz_br || is_loop_reg)
      len = `BIU_LEN2;
    else
      len = `BIU_LEN1;
  end
  wire [15:0] next_seq = pc_in + len;

  // relative offset byte: last byte of the instruction
  wire [7:0] rel = (is_compare || is_loop_dir) ? byte2 : byte1;
  wire [15:0] rel_target = next_seq + {{8{rel[7]}}, rel};
  wire [15:0] abs_target = {next_seq[15:`BIU_ABS_LO],
                            op[7:`BIU_ABS_HI_BIT], byte1};
  wire [15:0] long_target = {byte1, byte2};
  wire [15:0] ind_target = data_pointer + {8'h00, acc};

  ////////////////////////////////////////////////////////////////
  // return stack
  wire [15:0] stk_top;
  wire stk_empty;
  wire do_call = exec & (is_long_call | is_block_call);
  wire do_ret = exec & (is_sub_return | is_int_return);
  // push follow-on address, pop on return
  biu_stack #(
    .DEPTH_W(STACK_W)
  ) u_stack (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .push(do_call),
    .pop(do_ret),
    .push_addr(next_seq),
    .top_addr(stk_top),
    .empty(stk_empty)
  );

  ////////////////////////////////////////////////////////////////
  // conditions
  wire [7:0] dec_val = opnd_a - 8'h01;
  wire acc_zero = (acc == 8'h00);
  wire loop_go = (dec_val != 8'h00);
  wire cmp_go = (opnd_a != opnd_b);
  wire cmp_lt = (opnd_a < opnd_b);

  ////////////////////////////////////////////////////////////////
  // next-state selection
  reg [15:0] next_pc;
  reg next_taken;
  always @* begin
    next_pc = next_seq;
    next_taken = 1'b0;
    if (is_short) begin
      next_pc = rel_target;
      next_taken = 1'b1;
    end else if (is_long || is_long_call) begin
      next_pc = long_target;
      next_taken = 1'b1;
    end else if (is_block_jump || is_block_call) begin
      next_pc = abs_target;
      next_taken = 1'b1;
    end else if (is_ind) begin
      next_pc = ind_target;
      next_taken = 1'b1;
    end else if (is_sub_return || is_int_return) begin
      next_pc = stk_top;
      next_taken = 1'b1;
    end else if ((is_acc_zero_br && acc_zero) ||
                 (is_acc_nz_br && !acc_zero) ||
                 (is_loop && loop_go) || (is_compare && cmp_go)) begin
      next_pc = rel_target;
      next_taken = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // registered outputs; strobes last one enabled cycle
  always @(posedge ref_clk) begin
    if (srst) begin
      pc_out <= `BIU_PC_RST;
      pc_valid <= 1'b0;
      taken <= 1'b0;
      carry_out <= 1'b0;
      carry_we <= 1'b0;
      dec_out <= 8'h00;
      dec_we <= 1'b0;
      int_done <= 1'b0;
      stack_empty <= 1'b1;
    end else if (ce) begin
      stack_empty <= stk_empty;
      pc_valid <= exec;
      taken <= exec & next_taken;
      carry_we <= exec & is_compare;
      dec_we <= exec & is_loop;
      int_done <= exec & is_int_return & int_active;
      if (exec) begin
        pc_out <= next_pc;
        if (is_loop)
          dec_out <= dec_val;
        if (is_compare)
          carry_out <= cmp_lt;
        else
          carry_out <= carry_in;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/biu_props.sv
// port checker for the branch unit
`default_nettype none
module biu_props (
  input wire logic ref_clk, // clk
  input wire logic srst, // rst
  input wire logic ce, // en
  input wire logic exec, // go
  input wire logic [7:0] op, // op
  input wire logic [7:0] byte1, // b1
  input wire logic [7:0] byte2, // b2
  input wire logic [15:0] pc_in, // pc
  input wire logic [7:0] acc, // a
  input wire logic [15:0] data_pointer, // dp
  input wire logic [7:0] opnd_a, // x
  input wire logic [7:0] opnd_b, // y
  input wire logic int_active, // irq
  input wire logic [15:0] pc_out, // npc
  input wire logic taken, // jmp
  input wire logic carry_out, // cy
  input wire logic [7:0] dec_out, // dec
  input wire logic int_done // end
);
  timeunit 1ns;
  timeprecision 1ps;
  wire go;
  assign go = ce & exec;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // answers land one cycle after the strobe, so inputs are seen via $past
  a_short_target: assert property (go && op == 8'h80 |=> taken &&
    pc_out == $past(pc_in) + 16'h0002 + {{8{$past(byte1[7])}}, $past(byte1)})
    else $error("short jump target wrong");
  a_long_target: assert property (go && op == 8'h02 |=> taken &&
    pc_out == {$past(byte1), $past(byte2)}) else $error("long target wrong");
  a_block_target: assert property (go && op[3:0] == 4'h1 |=>
    pc_out[10:0] == {$past(op[7:5]), $past(byte1)} &&
    pc_out >> 11 == ($past(pc_in) + 16'h0002) >> 11)
    else $error("block target wrong");
  a_indirect_sum: assert property (go && op == 8'h73 |=>
    pc_out == $past(data_pointer) + {8'h00, $past(acc)})
    else $error("indirect target wrong");
  a_interrupt_return_notify: assert property (go && op == 8'h32 |=>
    int_done == $past(int_active)) else $error("interrupt done wrong");
  a_zero_test: assert property (go && (op == 8'h60 || op == 8'h70) |=>
    taken == (($past(acc) == 8'h00) ^ $past(op[4])))
    else $error("zero test wrong");
  a_loop_count: assert property (go && (op == 8'hd5 || op[7:3] == 5'h1b)
    |=> dec_out == $past(opnd_a) - 8'h01 && taken == ($past(opnd_a) != 8'h01))
    else $error("loop branch wrong");
  a_cmp_carry: assert property (go && op[7:4] == 4'hb && op[3:0] >= 4'h4
    |=> carry_out == ($past(opnd_a) < $past(opnd_b)) &&
    taken == ($past(opnd_a) != $past(opnd_b))) else $error("compare wrong");
endmodule
bind biu_branch_unit biu_props biu_props_inst (.*);
`default_nettype wire

// >>> test/biu_irq_model.sv
// interrupt control model facing the branch unit
`default_nettype none
module biu_irq_model (
  input wire logic ref_clk, // clock
  input wire logic srst, // reset
  input wire logic int_req, // start of a service
  input wire logic int_done, // end signalled by the unit
  output logic int_active // service in progress
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge ref_clk) begin
    if (srst || int_done) int_active <= 1'b0;
    else if (int_req) int_active <= 1'b1;
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the branch unit
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, srst = 1'b1, ce = 1'b1, exec = 1'b0;
  logic carry_in = 1'b0, int_req = 1'b0;
  logic [7:0] op = 8'h00, byte1 = 8'h00, byte2 = 8'h00, acc = 8'h00;
  logic [7:0] opnd_a = 8'h00, opnd_b = 8'h00, dec_out;
  logic [15:0] pc_in = 16'h0000, data_pointer = 16'h0000, pc_out;
  logic pc_valid, taken, carry_out, carry_we, dec_we, int_done;
  logic stack_empty, int_active;
  int err_count = 0;
  int compares = 0;
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
  biu_branch_unit biu_branch_unit_inst (.*);
  biu_irq_model biu_irq_model_inst (.*);
  ////////////////////////////////////////
  // one strobe; outputs settle just after the answering edge
  task automatic jt(input logic [7:0] o, b1, b2, input logic [15:0] pc, ep,
    input logic et);
    @(posedge ref_clk);
    exec <= 1'b1;
    op <= o;
    byte1 <= b1;
    byte2 <= b2;
    pc_in <= pc;
    @(posedge ref_clk);
    exec <= 1'b0;
    #1;
    `CHK(pc_out, ep)
    `CHK(taken, et)
    `CHK(pc_valid, 1'b1)
  endtask
  task automatic t_jumps();
    jt(8'h80, 8'h80, 8'h00, 16'h0100, 16'h0082, 1'b1);
    jt(8'h80, 8'h7f, 8'h00, 16'h0100, 16'h0181, 1'b1);
    jt(8'h02, 8'hab, 8'hcd, 16'h0100, 16'habcd, 1'b1);
    jt(8'he1, 8'h5a, 8'h00, 16'h37fe, 16'h3f5a, 1'b1);
    jt(8'h41, 8'h00, 8'h00, 16'hf000, 16'hf200, 1'b1);
    @(posedge ref_clk);
    acc <= 8'hff;
    data_pointer <= 16'hff02;
    jt(8'h73, 8'h00, 8'h00, 16'h0000, 16'h0001, 1'b1);
  endtask
  // nested calls unwind in reverse order
  task automatic t_calls();
    jt(8'h12, 8'h12, 8'h34, 16'h0200, 16'h1234, 1'b1);
    jt(8'h31, 8'h00, 8'h00, 16'h12fe, 16'h1100, 1'b1);
    jt(8'h22, 8'h00, 8'h00, 16'h1100, 16'h1300, 1'b1);
    @(posedge ref_clk);
    int_req <= 1'b1;
    @(posedge ref_clk);
    int_req <= 1'b0;
    jt(8'h32, 8'h00, 8'h00, 16'h1250, 16'h0203, 1'b1);
    `CHK(int_done, 1'b1)
    // the empty flag is registered one cycle behind the pop
    @(posedge ref_clk);
    #1;
    `CHK(stack_empty, 1'b1)
    jt(8'h12, 8'h05, 8'h00, 16'h0010, 16'h0500, 1'b1);
    jt(8'h32, 8'h00, 8'h00, 16'h0500, 16'h0013, 1'b1);
    `CHK(int_done, 1'b0)
  endtask
  task automatic cmp(input logic [7:0] o, x, y, input logic [15:0] ep,
    input logic c);
    @(posedge ref_clk);
    opnd_a <= x;
    opnd_b <= y;
    jt(o, 8'h00, 8'h08, 16'h0500, ep, ep != 16'h0503);
    `CHK(carry_out, c)
    `CHK(carry_we, 1'b1)
  endtask
  task automatic t_cond();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      acc <= i[0] ? 8'h01 : 8'h00;
      jt(i[1] ? 8'h70 : 8'h60, 8'h10, 8'h00, 16'h0400,
        (i[0] == i[1]) ? 16'h0412 : 16'h0402, i[0] == i[1]);
    end
    @(posedge ref_clk);
    opnd_a <= 8'h01;
    jt(8'hd5, 8'h00, 8'hf0, 16'h0400, 16'h0403, 1'b0);
    `CHK(dec_out, 8'h00)
    `CHK(dec_we, 1'b1)
    @(posedge ref_clk);
    opnd_a <= 8'h00;
    jt(8'hdf, 8'hf0, 8'h00, 16'h0400, 16'h03f2, 1'b1);
    `CHK(dec_out, 8'hff)
    cmp(8'hb4, 8'h05, 8'h06, 16'h050b, 1'b1);
    cmp(8'hb4, 8'h06, 8'h06, 16'h0503, 1'b0);
    cmp(8'hbf, 8'hff, 8'h00, 16'h050b, 1'b0);
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////
  // free-running core clock
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // a hung run still reaches the verdict
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    t_jumps();
    t_calls();
    t_cond();
    conclude();
  end
endmodule
`default_nettype wire
